/* File: src/spcd_pkg.sv */
package spcd_pkg;

  // ----------------------------------------
  // geometry
  // ----------------------------------------
  localparam int NUM_CH     = 6;
  localparam int FRAME_BITS = 16;
  localparam int CNT_W      = 4;
  localparam int DIAG_W     = NUM_CH + 1;

  // ----------------------------------------
  // serial command word fields
  // ----------------------------------------
  localparam int CMD_CH_LSB   = 0;
  localparam int CMD_AND_BIT  = 6;
  localparam int CMD_OTM_BIT  = 7;
  localparam int CMD_CLR_BIT  = 8;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS  = 8;
  localparam int FILTER_TIME_NS = 10000;
  localparam int FILTER_CYCLES  = (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_W         = 11;

  // ----------------------------------------
  // synchroniser bundle layout
  // ----------------------------------------
  localparam int SY_PAR   = 0;
  localparam int SY_DIS   = 6;
  localparam int SY_RST   = 7;
  localparam int SY_EDGE  = 8;
  localparam int SY_OVL   = 9;
  localparam int SY_OVT   = 15;
  localparam int SY_OPEN  = 21;
  localparam int SY_BYP   = 27;
  localparam int SY_LOT   = 33;
  localparam int SY_CS    = 34;
  localparam int SY_TOG   = 35;
  localparam int SYNC_W   = 36;

  // pin defaults: disable, reset and chip select idle high
  localparam logic [SYNC_W-1:0] SYNC_RST = 36'h4_0000_00c0;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [NUM_CH-1:0] CH_RST   = 6'h00;
  localparam logic [DIAG_W-1:0] DIAG_RST = 7'h00;

  typedef enum logic {ST_STANDBY, ST_ACTIVE} spcd_pwr_type;

endpackage

/* File: src/spcd_fault_filter.sv */
`timescale 1ns/10ps
module spcd_fault_filter
  import spcd_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic hold_i,
  input  wire logic raw_i,
  output logic      filt_o
);
  import spcd_pkg::*;

  logic [FILT_W-1:0] cnt;

  // no storage: a gap in the condition restarts the count
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || hold_i || !raw_i)
      cnt <= '0;
    else if (cnt != FILT_W'(FILTER_CYCLES))
      cnt <= cnt + FILT_W'(1);
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || hold_i || !raw_i)
      filt_o <= 1'b0;
    else
      filt_o <= (cnt == FILT_W'(FILTER_CYCLES));
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  filter_wait_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(filt_o) |-> $past(raw_i) && $past(cnt) == FILT_W'(FILTER_CYCLES))
    else $error("fault reported before filter time");

  filter_drop_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !raw_i |=> !filt_o)
    else $error("filtered fault outlived its cause");

endmodule

/* File: src/spcd_top.sv */
`timescale 1ns/10ps
module spcd_top
(
  input  wire logic                       clk_i,
  input  wire logic                       sys_rst_i,
  input  wire logic                       sclk_i,
  input  wire logic                       cs_n_i,
  input  wire logic                       si_i,
  output logic                            so_o,
  input  wire logic [spcd_pkg::NUM_CH-1:0] parallel_channel_input_i,
  input  wire logic                       global_output_disable_n_i,
  input  wire logic                       reset_n_i,
  input  wire logic                       spi_edge_select_i,
  input  wire logic [spcd_pkg::NUM_CH-1:0] overload_i,
  input  wire logic [spcd_pkg::NUM_CH-1:0] overheat_i,
  input  wire logic [spcd_pkg::NUM_CH-1:0] open_load_i,
  input  wire logic [spcd_pkg::NUM_CH-1:0] bypass_i,
  input  wire logic                       logic_overheat_i,
  output logic      [spcd_pkg::NUM_CH-1:0] power_out_o,
  output logic      [spcd_pkg::NUM_CH-2:0] channel_status_out_o,
  output logic                            channel6_status_or_overheat_flag_o,
  output logic                            fault_o,
  output logic                            fault_oe_n_o,
  output logic                            standby_o,
  output logic                            bias_en_o,
  output logic                            input_pulldown_en_o,
  output logic                            ctrl_pullup_en_o,
  output logic                            sclk_pullup_en_o,
  output logic                            sclk_pulldown_en_o
);
  import spcd_pkg::*;

  // ----------------------------------------
  // serial link domain
  // ----------------------------------------
  logic                  spi_clk;
  logic [CNT_W-1:0]      bit_cnt;
  logic [FRAME_BITS-1:0] shift_reg;
  logic [FRAME_BITS-1:0] rx_word;
  logic                  rx_toggle;
  logic [FRAME_BITS-1:0] tx_hold;

  // edge select is a strap; flipping it mid-frame glitches the link clock
  assign spi_clk = sclk_i ^ spi_edge_select_i;

  // chip select high is the frame's own end: counter cleared without an edge
  always_ff @(posedge spi_clk or posedge cs_n_i)
  begin
    if (cs_n_i)
      bit_cnt <= '0;
    else
      bit_cnt <= bit_cnt + CNT_W'(1);
  end

  always_ff @(posedge spi_clk or posedge cs_n_i)
  begin
    if (cs_n_i)
      shift_reg <= '0;
    else
      shift_reg <= {shift_reg[FRAME_BITS-2:0], si_i};
  end

  always_ff @(posedge spi_clk or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      rx_word <= '0;
    else if (!cs_n_i && bit_cnt == CNT_W'(FRAME_BITS - 1))
      rx_word <= {shift_reg[FRAME_BITS-2:0], si_i};
  end

  always_ff @(posedge spi_clk or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      rx_toggle <= 1'b0;
    else if (!cs_n_i && bit_cnt == CNT_W'(FRAME_BITS - 1))
      rx_toggle <= ~rx_toggle;
  end

  // output changes on the opposite edge to sampling
  always_ff @(negedge spi_clk or posedge cs_n_i or posedge sys_rst_i)
  begin
    if (cs_n_i || sys_rst_i)
      so_o <= 1'b0;
    else
      so_o <= tx_hold[CNT_W'(FRAME_BITS - 1) - bit_cnt];
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [SYNC_W-1:0] raw_async;
  logic [SYNC_W-1:0] sync_meta;
  logic [SYNC_W-1:0] sync_q;

  assign raw_async = {rx_toggle, cs_n_i, logic_overheat_i, bypass_i, open_load_i,
                      overheat_i, overload_i, spi_edge_select_i, reset_n_i,
                      global_output_disable_n_i, parallel_channel_input_i};

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      sync_meta <= SYNC_RST;
      sync_q    <= SYNC_RST;
    end
    else
    begin
      sync_meta <= raw_async;
      sync_q    <= sync_meta;
    end
  end

  logic [NUM_CH-1:0] par_in;
  logic [NUM_CH-1:0] ovl_s;
  logic [NUM_CH-1:0] ovt_s;
  logic [NUM_CH-1:0] open_s;
  logic [NUM_CH-1:0] byp_s;
  logic              dis_n_s;
  logic              rst_n_s;
  logic              edge_s;
  logic              lot_s;
  logic              cs_n_s;
  logic              tog_s;

  assign par_in  = sync_q[SY_PAR +: NUM_CH];
  assign ovl_s   = sync_q[SY_OVL +: NUM_CH];
  assign ovt_s   = sync_q[SY_OVT +: NUM_CH];
  assign open_s  = sync_q[SY_OPEN +: NUM_CH];
  assign byp_s   = sync_q[SY_BYP +: NUM_CH];
  assign dis_n_s = sync_q[SY_DIS];
  assign rst_n_s = sync_q[SY_RST];
  assign edge_s  = sync_q[SY_EDGE];
  assign lot_s   = sync_q[SY_LOT];
  assign cs_n_s  = sync_q[SY_CS];
  assign tog_s   = sync_q[SY_TOG];

  // ----------------------------------------
  // power state
  // ----------------------------------------
  spcd_pwr_type state;
  logic         standby;

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      state <= ST_STANDBY;
    else
      state <= rst_n_s ? ST_ACTIVE : ST_STANDBY;
  end

  assign standby = (state == ST_STANDBY);

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      standby_o <= 1'b1;
      bias_en_o <= 1'b0;
    end
    else
    begin
      standby_o <= !rst_n_s;
      bias_en_o <= rst_n_s;
    end
  end

  // ----------------------------------------
  // command capture
  // ----------------------------------------
  logic              tog_seen;
  logic              frame_new;
  logic [NUM_CH-1:0] spi_bits;
  logic              and_mode;
  logic              ot_flag_mode;
  logic              diag_clr;

  // rx_word has been stable since the toggle's own link edge, two clocks or more, when the toggle lands
  assign frame_new = (tog_s != tog_seen);

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      tog_seen <= 1'b0;
    else
      tog_seen <= tog_s;
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || standby)
    begin
      spi_bits     <= CH_RST;
      and_mode     <= 1'b0;
      ot_flag_mode <= 1'b0;
    end
    else if (frame_new)
    begin
      spi_bits     <= rx_word[CMD_CH_LSB +: NUM_CH];
      and_mode     <= rx_word[CMD_AND_BIT];
      ot_flag_mode <= rx_word[CMD_OTM_BIT];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      diag_clr <= 1'b0;
    else
      diag_clr <= frame_new && rx_word[CMD_CLR_BIT];
  end

  // ----------------------------------------
  // output stage
  // ----------------------------------------
  logic [NUM_CH-1:0] chan_cmd;

  assign chan_cmd = and_mode ? (par_in & spi_bits) : (par_in | spi_bits);

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || standby || !dis_n_s)
      power_out_o <= CH_RST;
    else
      power_out_o <= chan_cmd;
  end

  // ----------------------------------------
  // fault filtering
  // ----------------------------------------
  logic [NUM_CH-1:0] fault_raw;
  logic [NUM_CH-1:0] fault_filt;
  logic [NUM_CH-1:0] ot_filt;

  for (genvar i = 0; i < NUM_CH; i++)
  begin : g_ch
    // on-state faults only while driven, off-state faults only while off
    assign fault_raw[i] = power_out_o[i] ? (ovl_s[i] | ovt_s[i]) : (open_s[i] | byp_s[i]);

    spcd_fault_filter u_fault
    (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .hold_i    (standby),
      .raw_i     (fault_raw[i]),
      .filt_o    (fault_filt[i])
    );

    spcd_fault_filter u_heat
    (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .hold_i    (standby),
      .raw_i     (power_out_o[i] & ovt_s[i]),
      .filt_o    (ot_filt[i])
    );
  end

  // ----------------------------------------
  // status pins
  // ----------------------------------------
  logic heat_any;

  assign heat_any = (|ot_filt) | lot_s;

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || standby)
      channel_status_out_o <= '0;
    else
      channel_status_out_o <= chan_cmd[NUM_CH-2:0] ^ fault_filt[NUM_CH-2:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || standby)
      channel6_status_or_overheat_flag_o <= 1'b0;
    else if (ot_flag_mode)
      channel6_status_or_overheat_flag_o <= !heat_any;
    else
      channel6_status_or_overheat_flag_o <= chan_cmd[NUM_CH-1] ^ fault_filt[NUM_CH-1];
  end

  // ----------------------------------------
  // diagnosis register and fault pin
  // ----------------------------------------
  logic [DIAG_W-1:0] diag_reg;
  logic [DIAG_W-1:0] next_diag;

  // a fault arriving with the clear survives it
  always_comb
  begin
    if (standby)
      next_diag = DIAG_RST;
    else
      next_diag = (diag_clr ? DIAG_RST : diag_reg) | {lot_s, fault_filt};
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      diag_reg <= DIAG_RST;
    else
      diag_reg <= next_diag;
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      fault_oe_n_o <= 1'b1;
    else
      fault_oe_n_o <= ~(|next_diag);
  end

  // open drain: the pin is only ever pulled low
  always_ff @(posedge clk_i)
  begin
    fault_o <= 1'b0;
  end

  // snapshot for readback only while no frame runs
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      tx_hold <= '0;
    else if (cs_n_s)
      tx_hold <= {{(FRAME_BITS - DIAG_W){1'b0}}, diag_reg};
  end

  // ----------------------------------------
  // pull control
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      input_pulldown_en_o <= 1'b1;
      ctrl_pullup_en_o    <= 1'b1;
      sclk_pullup_en_o    <= 1'b1;
      sclk_pulldown_en_o  <= 1'b0;
    end
    else
    begin
      input_pulldown_en_o <= 1'b1;
      ctrl_pullup_en_o    <= 1'b1;
      sclk_pullup_en_o    <= !edge_s;
      sclk_pulldown_en_o  <= edge_s;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  disable_off_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !dis_n_s |=> power_out_o == CH_RST)
    else $error("output on while globally disabled");

  standby_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !rst_n_s |=> ##1 (power_out_o == CH_RST && diag_reg == DIAG_RST && spi_bits == CH_RST))
    else $error("standby did not clear state");

  fault_pull_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!standby && (|fault_filt)) |=> !fault_oe_n_o)
    else $error("fault pin not pulled on latched error");

  fault_release_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (diag_clr && fault_filt == '0 && !lot_s) |=> fault_oe_n_o)
    else $error("fault pin not released after clear");

  status_follow_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!standby && fault_filt == '0) |=> channel_status_out_o == $past(chan_cmd[NUM_CH-2:0]))
    else $error("status pin does not follow input");

  status_invert_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!standby && fault_filt[0]) |=> channel_status_out_o[0] != $past(chan_cmd[0]))
    else $error("status pin not inverted on fault");

  heat_flag_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!standby && ot_flag_mode && heat_any) |=> !channel6_status_or_overheat_flag_o)
    else $error("overheat flag not asserted");

  sclk_pull_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    edge_s |=> (sclk_pulldown_en_o && !sclk_pullup_en_o))
    else $error("serial clock pull wrong for edge select");

  sample_edge_a: assert property (@(posedge spi_clk) disable iff (cs_n_i || sys_rst_i)
    bit_cnt != CNT_W'(0) |-> shift_reg[0] == $past(si_i))
    else $error("serial data not taken on sample edge");

endmodule

/* File: tb/spcd_host_model.sv */
`timescale 1ns/10ps
module spcd_host_model
(
  input  wire logic edge_i,
  input  wire logic so_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      si_o
);
  logic sclk_r;
  logic in_frame;

  // clock stands at its inactive level between frames
  assign sclk_o = in_frame ? sclk_r : ~edge_i;

  initial
  begin
    in_frame = 1'b0;
    sclk_r   = 1'b0;
    cs_n_o   = 1'b1;
    si_o     = 1'b0;
  end

  // 16 bits msb first, 6 ns link period
  task automatic frame(input logic [15:0] word, output logic [15:0] rx);
    sclk_r   = ~edge_i;
    in_frame = 1'b1;
    cs_n_o   = 1'b0;
    #3;
    for (int i = 15; i >= 0; i--)
    begin
      sclk_r = edge_i;
      si_o   = word[i];
      #3;
      rx[i]  = so_i;
      sclk_r = ~edge_i;
      #3;
    end
    cs_n_o   = 1'b1;
    in_frame = 1'b0;
    // released data line falls to its pull-down
    si_o     = 1'b0;
  endtask
endmodule

/* File: tb/tb.sv */
`timescale 1ns/10ps
module tb;
  import spcd_pkg::*;

  logic              clk;
  logic              rst;
  logic              sclk;
  logic              cs_n;
  logic              si;
  logic              so;
  logic [NUM_CH-1:0] par;
  logic [NUM_CH-1:0] ovl;
  logic [NUM_CH-1:0] ovt;
  logic [NUM_CH-1:0] opn;
  logic [NUM_CH-1:0] byp;
  logic [NUM_CH-1:0] pwr;
  logic [NUM_CH-2:0] stat;
  logic              dis_n;
  logic              rst_n;
  logic              edge_sel;
  logic              lot;
  logic              flag6;
  logic              flt;
  logic              flt_oe_n;
  logic              fault_pin;
  logic              stby;
  logic              bias;
  logic              pd_en;
  logic              pu_en;
  logic              sck_pu;
  logic              sck_pd;
  logic [15:0]       rx;
  int                errors     = 0;
  int                num_checks = 0;
  int                cycles     = 0;

  // open-drain fault pin with its external pull-up
  assign fault_pin = flt_oe_n ? 1'b1 : flt;

  spcd_top i_spcd_top (
    .clk_i                              (clk),
    .sys_rst_i                          (rst),
    .sclk_i                             (sclk),
    .cs_n_i                             (cs_n),
    .si_i                               (si),
    .so_o                               (so),
    .parallel_channel_input_i           (par),
    .global_output_disable_n_i          (dis_n),
    .reset_n_i                          (rst_n),
    .spi_edge_select_i                  (edge_sel),
    .overload_i                         (ovl),
    .overheat_i                         (ovt),
    .open_load_i                        (opn),
    .bypass_i                           (byp),
    .logic_overheat_i                   (lot),
    .power_out_o                        (pwr),
    .channel_status_out_o               (stat),
    .channel6_status_or_overheat_flag_o (flag6),
    .fault_o                            (flt),
    .fault_oe_n_o                       (flt_oe_n),
    .standby_o                          (stby),
    .bias_en_o                          (bias),
    .input_pulldown_en_o                (pd_en),
    .ctrl_pullup_en_o                   (pu_en),
    .sclk_pullup_en_o                   (sck_pu),
    .sclk_pulldown_en_o                 (sck_pd)
  );

  spcd_host_model i_spcd_host_model (
    .edge_i (edge_sel),
    .so_i   (so),
    .sclk_o (sclk),
    .cs_n_o (cs_n),
    .si_o   (si)
  );

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask

  // commits need settling time before the next frame
  task automatic send(input logic [15:0] w);
    i_spcd_host_model.frame(w, rx);
    tick(10);
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      close_out();
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_edges();
    for (int e = 1; e >= 0; e--)
    begin
      edge_sel = e[0];
      rst = 1'b1;
      tick(4);
      rst = 1'b0;
      tick(6);
      chk(16'(sck_pu), 16'(e == 0), "sclk pull-up");
      chk(16'(sck_pd), 16'(e == 1), "sclk pull-down");
      chk(16'({pd_en, pu_en}), 16'h3, "pin pulls");
      send(16'h002a);
      chk(16'(pwr), 16'h2a, "serial word");
      send(16'h002a);
      chk(rx, 16'h0000, "empty readback");
    end
  endtask

  task automatic t_logic();
    logic [5:0] exp;
    par = 6'b001111;
    for (int m = 0; m < 2; m++)
    begin
      send({9'h0, m[0], 6'b010101});
      exp = m ? (par & 6'b010101) : (par | 6'b010101);
      chk(16'(pwr), 16'(exp), "combine");
      chk(16'({flag6, stat}), 16'(exp), "status follows");
      dis_n = 1'b0;
      tick(4);
      chk(16'(pwr), 16'h0, "disabled");
      dis_n = 1'b1;
      tick(4);
      chk(16'(pwr), 16'(exp), "re-enabled");
    end
    par = 6'h00;
  endtask

  task automatic t_fault();
    send(16'h0000);
    par = 6'h01;
    tick(4);
    // on-fault on a live channel, off-faults on two idle ones
    ovl[0] = 1'b1;
    opn[1] = 1'b1;
    byp[2] = 1'b1;
    tick(1200);
    chk(16'(stat), 16'h01, "filter early");
    chk(16'(fault_pin), 16'h1, "fault idle");
    tick(70);
    chk(16'(stat), 16'h06, "inverted");
    chk(16'(fault_pin), 16'h0, "fault low");
    ovl[0] = 1'b0;
    opn[1] = 1'b0;
    byp[2] = 1'b0;
    tick(6);
    chk(16'(stat), 16'h01, "not stored");
    send(16'h0000);
    chk(rx, 16'h0007, "diag readback");
    chk(16'(fault_pin), 16'h0, "fault sticky");
    send(16'h0100);
    chk(16'(fault_pin), 16'h1, "fault released");
    par = 6'h00;
  endtask

  task automatic t_heat();
    par = 6'h20;
    send(16'h0080);
    chk(16'(flag6), 16'h1, "flag idle");
    ovt[5] = 1'b1;
    tick(1270);
    chk(16'(flag6), 16'h0, "channel heat");
    ovt[5] = 1'b0;
    tick(4);
    send(16'h0180);
    chk(16'(flag6), 16'h1, "flag back");
    lot = 1'b1;
    tick(6);
    chk(16'(flag6), 16'h0, "die heat");
    lot = 1'b0;
    tick(6);
    send(16'h0100);
    chk(16'(fault_pin), 16'h1, "cleared");
    par = 6'h00;
  endtask

  task automatic t_standby();
    send(16'h003f);
    chk(16'(pwr), 16'h3f, "all on");
    rst_n = 1'b0;
    tick(6);
    chk(16'({stby, bias, pwr}), 16'h80, "standby");
    rst_n = 1'b1;
    tick(6);
    chk(16'({stby, bias, pwr}), 16'h40, "regs cleared");
  endtask

  initial
  begin
    rst      = 1'b1;
    par      = '0;
    ovl      = '0;
    ovt      = '0;
    opn      = '0;
    byp      = '0;
    dis_n    = 1'b1;
    rst_n    = 1'b1;
    edge_sel = 1'b0;
    lot      = 1'b0;
    tick(4);
    rst = 1'b0;
    tick(6);
    chk(16'({stby, bias, flt_oe_n}), 16'h3, "after reset");
    t_edges();
    t_logic();
    t_fault();
    t_heat();
    t_standby();
    close_out();
  end
endmodule
